// >>> design/tble_duty_regen.sv
// Purpose: Rebuild a 50 percent duty line clock from a skewed one
// Assumes: Input duty between 30 and 70 percent; period under 255 cycles
// Notes:   Half-period taken from the previous measured period
`timescale 1ns/10ps
`default_nettype none
module tble_duty_regen (
	input  wire logic i_clk,          // System clock
	input  wire logic i_rst,          // Async reset, high
	input  wire logic i_fall_stb,     // Falling edge of the line clock
	output logic      o_half_high     // Regenerated clock, high first half
);
	import tble_pkg::*;

	logic [PER_W-1:0] cnt;            // Cycles since last fall
	logic [PER_W-1:0] period;         // Last measured period

	// Period measurement; only falls are used, so the input duty drops out
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt    <= '0;
			period <= '0;
		end else if (i_fall_stb) begin
			cnt    <= '0;
			period <= (cnt == PER_MAX) ? PER_MAX : cnt + PER_ONE;
		end else if (cnt != PER_MAX) begin
			cnt <= cnt + PER_ONE;
		end
	end

	// High for half the period after each fall. The sum is formed one bit
	// wider: a saturated count must not wrap to zero and hold the clock high
	// while the line clock stands still.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_half_high <= 1'b0;
		end else if (i_fall_stb) begin
			o_half_high <= 1'b1;
		end else begin
			o_half_high <= ({1'b0, cnt} + {1'b0, PER_ONE}) < {2'b00, period[PER_W-1:1]};
		end
	end
endmodule : tble_duty_regen
`default_nettype wire

// >>> design/tble_encoder_top.sv
// Purpose: One channel of the transmit front end: rate select, rail format,
//          zero substitution and bipolar line pulse generation
// Assumes: All inputs synchronous to i_clk; line clock far slower than i_clk
// Notes:   Fixed four-bit look-ahead in every mode, bypass included
`timescale 1ns/10ps
`default_nettype none
module tble_encoder_top #(
	parameter logic [1:0] CHANNEL = 2'b00                     // Channel index, sets register base
) (
	input  wire logic                    i_clk,                   // System clock, 250 MHz
	input  wire logic                    i_rst,                   // Async reset, high
	input  wire logic                    i_config_source_pin,     // High register mode, low pin mode
	input  wire logic                    i_euro_rate_select,      // Pin mode euro rate
	input  wire logic                    i_sonet_rate_select,     // Pin mode sonet rate
	input  wire logic                    i_single_rail_select,    // Pin mode encoder bypass
	input  wire logic                    i_tx_positive_rail_in,   // Positive rail or binary data
	input  wire logic                    i_tx_negative_rail_in,   // Negative rail data
	input  wire logic                    i_tx_line_clock_in,      // Line rate clock from framer
	input  wire logic                    i_reg_wr,                // Register write strobe
	input  wire logic [tble_pkg::ADDR_W-1:0] i_reg_addr,          // Register address
	input  wire logic [tble_pkg::DATA_W-1:0] i_reg_wdata,         // Register write data
	output logic      [tble_pkg::DATA_W-1:0] o_reg_rdata,         // Register read data
	output tble_pkg::tble_rate_type      o_rate,                  // Active line rate
	output logic                         o_encoder_active,        // Zero substitution running
	output logic                         o_line_out_tip,          // Positive line pulse
	output logic                         o_line_out_ring          // Negative line pulse
);
	import tble_pkg::*;

	// Rate decode shared by the pin path and the register path
	function automatic tble_rate_type decode_rate(input logic euro, input logic sonet);
		tble_rate_type r;
		r = RATE_DS3;
		if (euro) begin
			r = RATE_E3;                                     // Sonet bit is a don't care here
		end else if (sonet) begin
			r = RATE_STS1;
		end
		return r;
	endfunction : decode_rate

	// Whether a symbol puts a pulse on the line
	function automatic logic is_pulse(input tble_sym_type s);
		return s != SYM_ZERO;
	endfunction : is_pulse

	logic [DATA_W-1:0]     rail_ctrl;          // Rail format and receive control
	logic [DATA_W-1:0]     rate_ctrl;          // Rate and loopback control
	logic [ADDR_W-1:0]     base;               // Channel register base
	logic                  hit_rail;           // Address selects rail register
	logic                  hit_rate;           // Address selects rate register
	logic                  host_mode;          // Register configured
	logic                  single_rail;        // Single rail input in use
	logic                  enc_on;             // Substitution encoder enabled
	tble_rate_type         rate;               // Selected rate
	logic                  fall_stb;           // Line clock falling edge
	logic                  smp_pos;            // Sampled positive rail
	logic                  smp_neg;            // Sampled negative rail
	logic                  half_high;          // Regenerated 50 percent clock
	tble_sym_type          sym [PIPE_DEPTH];   // Look-ahead slots, [0] newest
	logic [PIPE_DEPTH-1:0] byp_pos;            // Bypass positive pipe
	logic [PIPE_DEPTH-1:0] byp_neg;            // Bypass negative pipe
	logic                  par_odd;            // Odd pulses since last violation
	logic                  last_pos;           // Polarity of last line pulse
	logic                  run_hit;            // Zero run complete with new bit
	logic                  next_last_pos;      // Polarity after this output
	logic                  out_pos;            // Positive pulse for current bit
	logic                  out_neg;            // Negative pulse for current bit
	logic                  next_out_pos;       // Polarity pick for oldest slot
	logic                  next_out_neg;       // Polarity pick for oldest slot

	assign base     = ADDR_W'({CHANNEL, 3'b000});
	assign hit_rail = (i_reg_addr == base + OFF_RAIL_CTRL);
	assign hit_rate = (i_reg_addr == base + OFF_RATE_CTRL);

	// Command registers; reserved bits never store so they read zero
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rail_ctrl <= RAIL_RESET;
			rate_ctrl <= RATE_RESET;
		end else if (i_reg_wr) begin
			if (hit_rail) begin
				rail_ctrl <= i_reg_wdata & RAIL_WR_MASK;
			end
			if (hit_rate) begin
				rate_ctrl <= i_reg_wdata & RATE_WR_MASK;
			end
		end
	end

	// Read data from a register; unmapped addresses answer zero
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_reg_rdata <= '0;
		end else if (hit_rail) begin
			o_reg_rdata <= rail_ctrl;
		end else if (hit_rate) begin
			o_reg_rdata <= rate_ctrl;
		end else begin
			o_reg_rdata <= '0;
		end
	end

	// Configuration source; the pin level is trusted to be static
	always_comb begin
		host_mode = i_config_source_pin;
		if (host_mode) begin
			rate        = decode_rate(rate_ctrl[BIT_EURO], rate_ctrl[BIT_SONET]);
			single_rail = rail_ctrl[BIT_SINGLE];
			enc_on      = rail_ctrl[BIT_SINGLE];
		end else begin
			rate        = decode_rate(i_euro_rate_select, i_sonet_rate_select);
			single_rail = 1'b0;
			enc_on      = ~i_single_rail_select;
		end
	end

	// Rail capture on the falling line clock edge
	tble_fall_sampler u_sampler (
		.i_clk      (i_clk),
		.i_rst      (i_rst),
		.i_line_clk (i_tx_line_clock_in),
		.i_pos      (i_tx_positive_rail_in),
		.i_neg      (i_tx_negative_rail_in),
		.o_fall_stb (fall_stb),
		.o_pos      (smp_pos),
		.o_neg      (smp_neg)
	);

	// Half-period rebuild so pulse width does not follow input duty
	tble_duty_regen u_regen (
		.i_clk       (i_clk),
		.i_rst       (i_rst),
		.i_fall_stb  (fall_stb),
		.o_half_high (half_high)
	);

	// A zero run is complete when the new bit and the slots before it are
	// plain zeros; slots already substituted never match, so runs never overlap
	always_comb begin
		run_hit = ~smp_pos & (sym[0] == SYM_ZERO) & (sym[1] == SYM_ZERO);
		if (rate == RATE_E3) begin
			run_hit = run_hit & (sym[2] == SYM_ZERO);
		end
	end

	// Look-ahead pipe: shift on every bit, rewrite the run when it closes.
	// Depth is four in every mode so latency never depends on the data.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int i = 0; i < PIPE_DEPTH; i++) begin
				sym[i] <= SYM_ZERO;
			end
		end else if (fall_stb) begin
			for (int i = 1; i < PIPE_DEPTH; i++) begin
				sym[i] <= sym[i-1];
			end
			sym[0] <= smp_pos ? SYM_MARK : SYM_ZERO;
			if (enc_on && run_hit) begin
				sym[0] <= SYM_VIOL;
				if (!par_odd) begin
					// Even count so far: a B makes it odd before the V
					if (rate == RATE_E3) begin
						sym[3] <= SYM_BAL;
					end else begin
						sym[2] <= SYM_BAL;
					end
				end
			end
		end
	end

	// Parity of pulses since the last violation, kept at the input side
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			par_odd <= 1'b0;
		end else if (fall_stb) begin
			if (enc_on && run_hit) begin
				par_odd <= 1'b0;
			end else if (smp_pos) begin
				par_odd <= ~par_odd;
			end
		end
	end

	// Bypass pipes carry both rails with the same latency
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			byp_pos <= '0;
			byp_neg <= '0;
		end else if (fall_stb) begin
			byp_pos <= {byp_pos[PIPE_DEPTH-2:0], smp_pos};
			byp_neg <= {byp_neg[PIPE_DEPTH-2:0], smp_neg};
		end
	end

	// Polarity of the oldest slot
	always_comb begin
		next_out_pos  = 1'b0;
		next_out_neg  = 1'b0;
		next_last_pos = last_pos;
		if (enc_on) begin
			unique case (sym[PIPE_DEPTH-1])
				SYM_ZERO: begin
					next_last_pos = last_pos;                // No pulse, polarity kept
				end
				SYM_MARK, SYM_BAL: begin
					next_last_pos = ~last_pos;
				end
				SYM_VIOL: begin
					next_last_pos = last_pos;
				end
			endcase
			if (is_pulse(sym[PIPE_DEPTH-1])) begin
				next_out_pos = next_last_pos;
				next_out_neg = ~next_last_pos;
			end
		end else begin
			next_out_pos = byp_pos[PIPE_DEPTH-1];
			next_out_neg = byp_neg[PIPE_DEPTH-1];
			if (next_out_pos != next_out_neg) begin
				next_last_pos = next_out_pos;                // Track so a switch to coding alternates
			end
		end
	end

	// Per-bit output symbol and last polarity, updated once per bit
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			out_pos  <= 1'b0;
			out_neg  <= 1'b0;
			last_pos <= 1'b0;
		end else if (fall_stb) begin
			out_pos  <= next_out_pos;
			out_neg  <= next_out_neg;
			last_pos <= next_last_pos;
		end
	end

	// Line pulses are half a bit wide, timed by the regenerated clock
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_line_out_tip  <= 1'b0;
			o_line_out_ring <= 1'b0;
		end else begin
			o_line_out_tip  <= out_pos & half_high;
			o_line_out_ring <= out_neg & half_high;
		end
	end

	// Status outputs from flip-flops
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rate           <= RATE_DS3;
			o_encoder_active <= 1'b0;
		end else begin
			o_rate           <= rate;
			o_encoder_active <= enc_on | single_rail;
		end
	end
endmodule : tble_encoder_top
`default_nettype wire

// >>> design/tble_fall_sampler.sv
// Purpose: Detect the falling edge of the line clock and catch both rails
// Assumes: Line clock and rails synchronous to i_clk, far slower than it
// Notes:   Strobe is one i_clk cycle wide, rails held until the next fall
`timescale 1ns/10ps
`default_nettype none
module tble_fall_sampler (
	input  wire logic i_clk,          // System clock
	input  wire logic i_rst,          // Async reset, high
	input  wire logic i_line_clk,     // Line clock level
	input  wire logic i_pos,          // Positive rail
	input  wire logic i_neg,          // Negative rail
	output logic      o_fall_stb,     // One-cycle pulse per falling edge
	output logic      o_pos,          // Sampled positive rail
	output logic      o_neg           // Sampled negative rail
);
	import tble_pkg::*;

	logic             clk_prev;       // Line clock one cycle ago
	logic             fall;           // Falling edge seen now

	assign fall = clk_prev & ~i_line_clk;

	// Edge history
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			clk_prev <= 1'b0;
		end else begin
			clk_prev <= i_line_clk;
		end
	end

	// Catch rails on the falling edge only
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_fall_stb <= 1'b0;
			o_pos      <= 1'b0;
			o_neg      <= 1'b0;
		end else begin
			o_fall_stb <= fall;
			if (fall) begin
				o_pos <= i_pos;
				o_neg <= i_neg;
			end
		end
	end
endmodule : tble_fall_sampler
`default_nettype wire

// >>> design/tble_pkg.sv
// Purpose: Shared constants and types for the transmit bipolar line encoder
// Assumes: One channel per instance; register port carries 5-bit words
// Notes:   Offsets are channel-relative plus channel index times the stride
package tble_pkg;
	// Register map
	localparam int unsigned      ADDR_W        = 5;              // Register address width
	localparam int unsigned      DATA_W        = 5;              // Register data width (D4..D0)
	localparam logic [4:0]       CH_STRIDE     = 5'h08;          // Address span of one channel
	localparam logic [4:0]       OFF_RAIL_CTRL = 5'h03;          // Rail format and receive control
	localparam logic [4:0]       OFF_RATE_CTRL = 5'h04;          // Rate and loopback control
	localparam logic [4:0]       RAIL_RESET    = 5'h00;          // Reset value, rail format register
	localparam logic [4:0]       RATE_RESET    = 5'h00;          // Reset value, rate register
	localparam logic [4:0]       RAIL_WR_MASK  = 5'h1E;          // D0 reserved, reads zero
	localparam logic [4:0]       RATE_WR_MASK  = 5'h0F;          // D4 reserved, reads zero
	// Field positions
	localparam int unsigned      BIT_SINGLE    = 4;              // single_rail_select
	localparam int unsigned      BIT_MUTE      = 3;              // signal_loss_mute
	localparam int unsigned      BIT_RECEIVER_POWER_DOWN     = 2;              // receiver_power_down
	localparam int unsigned      BIT_RXINV     = 1;              // rx_clock_invert
	localparam int unsigned      BIT_SONET     = 3;              // sonet_rate_select
	localparam int unsigned      BIT_EURO      = 2;              // euro_rate_select
	localparam int unsigned      BIT_LLB       = 1;              // local_loopback_enable
	localparam int unsigned      BIT_RLB       = 0;              // remote_loopback_enable
	// Encoder pipeline
	localparam int unsigned      PIPE_DEPTH    = 4;              // Look-ahead depth, fixed latency
	localparam int unsigned      RUN_HDB3      = 4;              // Zero run replaced in HDB3
	localparam int unsigned      RUN_B3ZS      = 3;              // Zero run replaced in B3ZS
	// Duty regeneration
	localparam int unsigned      PER_W         = 8;              // Period counter width
	localparam logic [7:0]       PER_MAX       = 8'hFF;          // Counter saturation
	localparam logic [7:0]       PER_ONE       = 8'h01;          // Count step
	// Line rates, kept for reference by the bench
	localparam real              RATE_E3_MHZ   = 34.368;         // Euro rate clock
	localparam real              RATE_DS3_MHZ  = 44.736;         // DS3 rate clock
	localparam real              RATE_STS1_MHZ = 51.84;          // SONET rate clock
	localparam real              SYS_CLK_MHZ   = 250.0;          // System clock
	localparam int unsigned      MIN_PERIOD_CYC = int'(SYS_CLK_MHZ / RATE_STS1_MHZ); // Fastest line bit, cycles

	// Line rate selection
	typedef enum logic [1:0] {
		RATE_DS3  = 2'b00,
		RATE_STS1 = 2'b01,
		RATE_E3   = 2'b10
	} tble_rate_type;

	// Symbol held in each look-ahead slot
	typedef enum logic [1:0] {
		SYM_ZERO = 2'b00,                                    // No pulse
		SYM_MARK = 2'b01,                                    // Data one, AMI
		SYM_BAL  = 2'b10,                                    // Inserted B pulse, AMI
		SYM_VIOL = 2'b11                                     // Inserted V pulse, same polarity
	} tble_sym_type;
endpackage : tble_pkg

// >>> sim/tble_encoder_properties.sv
// Purpose: Port-level checks of one encoder channel
// Assumes: One clock, async high reset
// Notes:   Bound into every encoder top
`timescale 1ns/10ps
`default_nettype none
module tble_encoder_properties #(
	parameter logic [1:0] CHANNEL = 2'b00         // Channel index
) (
	input wire logic                          i_clk,                 // System clock
	input wire logic                          i_rst,                 // Async reset
	input wire logic                          i_config_source_pin,   // Register mode
	input wire logic                          i_euro_rate_select,    // Pin euro
	input wire logic                          i_sonet_rate_select,   // Pin sonet
	input wire logic                          i_single_rail_select,  // Pin bypass
	input wire logic                          i_tx_positive_rail_in, // Positive rail
	input wire logic                          i_tx_negative_rail_in, // Negative rail
	input wire logic                          i_tx_line_clock_in,    // Line clock
	input wire logic                          i_reg_wr,              // Write strobe
	input wire logic [tble_pkg::ADDR_W-1:0]   i_reg_addr,            // Address
	input wire logic [tble_pkg::DATA_W-1:0]   i_reg_wdata,           // Write data
	input wire logic [tble_pkg::DATA_W-1:0]   o_reg_rdata,           // Read data
	input wire tble_pkg::tble_rate_type       o_rate,                // Active rate
	input wire logic                          o_encoder_active,      // Encoder on
	input wire logic                          o_line_out_tip,        // Positive pulse
	input wire logic                          o_line_out_ring        // Negative pulse
);
	import tble_pkg::*;
	localparam logic [4:0] RAIL_A = {CHANNEL, 3'h3}; // Rail register
	localparam logic [4:0] RATE_A = {CHANNEL, 3'h4}; // Rate register
	// All checks share the one clock; reset masks them
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	pulse_excl_a: assert property (!(o_line_out_tip && o_line_out_ring))
		else $error("tip and ring high together");
	reset_clear_a: assert property ($fell(i_rst) |-> o_reg_rdata == 5'h00 && !o_line_out_tip)
		else $error("outputs not clear after reset");
	pin_euro_a: assert property (!i_config_source_pin && i_euro_rate_select |=> o_rate == RATE_E3)
		else $error("pin euro rate not taken");
	pin_sonet_a: assert property (!i_config_source_pin && !i_euro_rate_select && i_sonet_rate_select
		|=> o_rate == RATE_STS1)
		else $error("pin sonet rate not taken");
	pin_ds3_a: assert property (!i_config_source_pin && !i_euro_rate_select && !i_sonet_rate_select
		|=> o_rate == RATE_DS3)
		else $error("pin ds3 rate not taken");
	reg_euro_a: assert property (i_config_source_pin && i_reg_wr && i_reg_addr == RATE_A && i_reg_wdata[2]
		##1 i_config_source_pin && !i_reg_wr |=> o_rate == RATE_E3)
		else $error("register euro rate not taken");
	reg_sonet_a: assert property (i_config_source_pin && i_reg_wr && i_reg_addr == RATE_A
		&& i_reg_wdata[3:2] == 2'b10 ##1 i_config_source_pin && !i_reg_wr |=> o_rate == RATE_STS1)
		else $error("register sonet rate not taken");
	rail_store_a: assert property (i_reg_wr && i_reg_addr == RAIL_A ##1 !i_reg_wr && $stable(i_reg_addr)
		|=> o_reg_rdata == ($past(i_reg_wdata, 2) & RAIL_WR_MASK))
		else $error("rail register readback wrong");
	unmapped_zero_a: assert property (i_reg_addr != RAIL_A && i_reg_addr != RATE_A |=> o_reg_rdata == 5'h00)
		else $error("unmapped address reads nonzero");
	pin_encoder_a: assert property (!i_config_source_pin |=> o_encoder_active == !$past(i_single_rail_select))
		else $error("encoder state wrong in pin mode");
endmodule : tble_encoder_properties
bind tble_encoder_top tble_encoder_properties #(.CHANNEL(CHANNEL)) tble_encoder_properties_i (
	.i_clk(i_clk), .i_rst(i_rst), .i_config_source_pin(i_config_source_pin),
	.i_euro_rate_select(i_euro_rate_select), .i_sonet_rate_select(i_sonet_rate_select),
	.i_single_rail_select(i_single_rail_select), .i_tx_positive_rail_in(i_tx_positive_rail_in),
	.i_tx_negative_rail_in(i_tx_negative_rail_in), .i_tx_line_clock_in(i_tx_line_clock_in),
	.i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
	.o_rate(o_rate), .o_encoder_active(o_encoder_active), .o_line_out_tip(o_line_out_tip),
	.o_line_out_ring(o_line_out_ring));
`default_nettype wire

// >>> sim/tble_framer_model.sv
// Purpose: Framer side: line clock and rail data
// Assumes: Line clock scaled to 20 system cycles a bit
// Notes:   Clock idles high between frames, so no stray falls
`timescale 1ns/10ps
`default_nettype none
module tble_framer_model (
	input  wire logic i_clk,       // System clock
	output logic      o_line_clk,  // Line clock
	output logic      o_pos,       // Positive rail
	output logic      o_neg        // Negative rail
);
	// Idle state before the first frame
	initial begin
		o_line_clk = 1'b1;
		o_pos = 1'b0;
		o_neg = 1'b0;
	end
	// One bit: rails change at the rise and hold across the fall
	task automatic send_bit(input logic p, input logic n, input int hi, input int lo);
		@(posedge i_clk);
		#1 o_line_clk = 1'b1;
		o_pos = p;
		o_neg = n;
		repeat (hi) @(posedge i_clk);
		#1 o_line_clk = 1'b0;
		repeat (lo - 1) @(posedge i_clk);
	endtask : send_bit
	// Between frames: clock parked high, stale data inverted
	task automatic idle();
		@(posedge i_clk);
		#1 o_line_clk = 1'b1;
		o_pos = ~o_pos;
		o_neg = ~o_neg;
	endtask : idle
endmodule : tble_framer_model
`default_nettype wire

// >>> sim/test_tx_bipolar_line_encoder.sv
// Purpose: Self-checking bench for one encoder channel
// Assumes: Channel 1 instance, line bit of 20 system cycles
// Notes:   Each line bit yields one observed symbol, four bits late
`timescale 1ns/10ps
`default_nettype none
module test_tx_bipolar_line_encoder;
	import tble_pkg::*;
	localparam logic [4:0]  RAIL_A = CH_STRIDE + OFF_RAIL_CTRL; // Channel 1 rail
	localparam logic [4:0]  RATE_A = CH_STRIDE + OFF_RATE_CTRL; // Channel 1 rate
	localparam logic [31:0] PAT    = 32'h00C91831;              // Mixed zero runs
	logic             clk, rst, cfg_pin, euro, sonet, single, wr; // Bench drives
	logic [4:0]       addr, wdata, rdata;                       // Register port
	tble_rate_type    rate;                                     // Active rate
	logic             enc_on, tip, ring, lclk, pos, neg;        // Line side
	logic [1:0]       seen, exp_s[32], syms[$];                 // Symbols {tip, ring}
	logic             prev_lc;                                  // Last line clock
	int               n_errors, compares, nfall, width;         // Counters
	tble_rate_type    rtab[4] = '{RATE_DS3, RATE_E3, RATE_STS1, RATE_E3}; // Decode table
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	tble_encoder_top #(.CHANNEL(2'b01)) tble_encoder_top_i (.i_clk(clk), .i_rst(rst),
		.i_config_source_pin(cfg_pin), .i_euro_rate_select(euro), .i_sonet_rate_select(sonet),
		.i_single_rail_select(single), .i_tx_positive_rail_in(pos), .i_tx_negative_rail_in(neg),
		.i_tx_line_clock_in(lclk), .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.o_reg_rdata(rdata), .o_rate(rate), .o_encoder_active(enc_on), .o_line_out_tip(tip),
		.o_line_out_ring(ring));
	tble_framer_model tble_framer_model_i (.i_clk(clk), .o_line_clk(lclk), .o_pos(pos), .o_neg(neg));
	// One symbol per line clock period; pulse widths once the period is known
	always @(posedge clk) begin
		if (tip || ring)
			width++;
		else if (width != 0) begin
			if (nfall > 7) begin
				compares++;
				if (width < 8 || width > 12) begin
					n_errors++;
					$display("ERROR pulse width expected 10 seen %0d", width);
				end
			end
			width = 0;
		end
		seen = seen | {tip, ring};
		if (prev_lc && !lclk) begin
			if (nfall > 0)
				syms.push_back(seen);
			seen = 2'b00;
			nfall++;
		end
		prev_lc = lclk;
	end
	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] got);
		compares++;
		if (got !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, e, got);
		end
	endtask : chk
	task automatic reg_write(input logic [4:0] a, input logic [4:0] d);
		@(posedge clk);
		#1 wr = 1'b1;
		addr = a;
		wdata = d;
		@(posedge clk);
		#1 wr = 1'b0;
	endtask : reg_write
	task automatic reg_read(input logic [4:0] a, input logic [4:0] e);
		@(posedge clk);
		#1 addr = a;
		repeat (2) @(posedge clk);
		#1 chk("register", {3'h0, e}, {3'h0, rdata});
	endtask : reg_read
	// Expected line symbols; run 0 means the encoder is bypassed
	task automatic build(input logic [31:0] b, input logic [31:0] nb, input int run);
		logic [1:0] last;
		int         cnt;
		int         i;
		last = 2'b01;
		cnt = 0;
		i = 0;
		while (i < 32) begin
			if (run == 0) begin
				exp_s[i] = {b[i], nb[i] & !b[i]};
				i++;
			end else if (i + run <= 32 && ((b >> i) & ((32'h1 << run) - 1)) == 0) begin
				for (int k = 0; k < run; k++)
					exp_s[i + k] = 2'b00;
				if (cnt % 2 == 0) begin
					last = ~last;
					exp_s[i] = last;
				end
				exp_s[i + run - 1] = last;
				cnt = 0;
				i += run;
			end else begin
				if (b[i]) begin
					last = ~last;
					cnt++;
				end
				exp_s[i] = b[i] ? last : 2'b00;
				i++;
			end
		end
	endtask : build
	// Reset, then configure through pins or registers
	task automatic start(input logic c, input logic s, input logic [4:0] rail, input logic [4:0] rt);
		@(posedge clk);
		#1 rst = 1'b1;
		cfg_pin = c;
		single = s;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		nfall = 0;
		syms.delete();
		if (c) begin
			reg_write(RAIL_A, rail);
			reg_write(RATE_A, rt);
		end
		repeat (3) @(posedge clk);
	endtask : start
	task automatic run_case(input logic [31:0] b, input logic [31:0] nb, input int run, input int hi);
		build(b, nb, run);
		for (int i = 0; i < 32; i++)
			tble_framer_model_i.send_bit(b[i], nb[i], hi, 20 - hi);
		tble_framer_model_i.idle();
		repeat (8) @(posedge clk);
		for (int i = 0; i < 24; i++)
			chk("line symbol", {6'h0, exp_s[i]}, {6'h0, syms[i + 4]});
	endtask : run_case
	task automatic test_done();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done
	// Watchdog: the tests need about 2700 cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		$display("ERROR watchdog expected finish seen timeout");
		test_done();
	end
	initial begin
		{rst, cfg_pin, euro, sonet, single, wr, addr, wdata} = {6'h20, 10'h000};
		{n_errors, compares, nfall, width, seen, prev_lc} = '0;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		reg_read(RAIL_A, RAIL_RESET);
		reg_read(RATE_A, RATE_RESET);
		reg_write(RAIL_A, 5'h1F);
		reg_write(5'h03, 5'h1F);
		reg_read(RAIL_A, 5'h1E);
		reg_read(5'h03, 5'h00);
		cfg_pin = 1'b1;
		for (int i = 0; i < 4; i++) begin
			reg_write(RATE_A, 5'h10 | 5'(i << 2));
			reg_read(RATE_A, 5'(i << 2));
			chk("register rate", {6'h0, rtab[i]}, {6'h0, rate});
		end
		cfg_pin = 1'b0;
		for (int i = 0; i < 4; i++) begin
			{sonet, euro} = 2'(i);
			repeat (2) @(posedge clk);
			#1 chk("pin rate", {6'h0, rtab[i]}, {6'h0, rate});
		end
		{sonet, euro} = 2'b00;
		start(1'b0, 1'b1, 5'h00, 5'h00);
		chk("encoder on", 8'h00, {7'h0, enc_on});
		run_case(32'h00A41290, 32'h001A0C44, 0, 10);
		start(1'b1, 1'b0, 5'h10, 5'h00);
		chk("encoder on", 8'h01, {7'h0, enc_on});
		run_case(PAT, 32'h55555555, 3, 6);
		start(1'b1, 1'b0, 5'h10, 5'h08);
		run_case(PAT, 32'hAAAAAAAA, 3, 14);
		start(1'b1, 1'b0, 5'h10, 5'h0C);
		run_case(PAT, 32'h33333333, 4, 10);
		test_done();
	end
endmodule : test_tx_bipolar_line_encoder
`default_nettype wire
